// *** design/smpt_consts.svh ***
/*
 Named constants for the message translator: codes, limits, bands and status.
 Assumes it is included by bare name by every design file that needs it.
*/
`ifndef SMPT_CONSTS_SVH
`define SMPT_CONSTS_SVH

// Native function codes
`define FC_RD_COIL 8'h01
`define FC_RD_INREL 8'h02
`define FC_RD_HOLD 8'h03
`define FC_RD_INREG 8'h04
`define FC_WR_COIL 8'h05
`define FC_WR_HOLD 8'h06
`define FC_LOOP 8'h08
`define FC_WR_COILS 8'h0f
`define FC_WR_HOLDS 8'h10

// Native address and size limits
`define ADR_MAX_WORD 16'hfffe
`define ADR_MAX_INREG 16'h7fff
`define LIM_BIT_RD 16'h07d0
`define LIM_WORD_RD 16'h007d
`define LIM_BIT_WR 16'h0320
`define LIM_WORD_WR 16'h0064

// Far-end per-command limits, in points or characters
`define PLC_BIT_RD 16'h0200
`define PLC_WORD_RD 16'h0040
`define PLC_BIT_WR 16'h00a0
`define PLC_WORD_WR 16'h0040
`define PLC_LOOP 16'h00fe

// Far-end commands of the common set
`define CMD_BIT_RD 8'h01
`define CMD_WORD_RD 8'h02
`define CMD_BIT_WR 8'h03
`define CMD_WORD_WR 8'h04
`define CMD_LOOP 8'h05

// Device codes sent to the far end
`define DEV_NONE 4'h0
`define DEV_OUT 4'h1
`define DEV_MREL 4'h2
`define DEV_SREL 4'h3
`define DEV_LREL 4'h4
`define DEV_ANN 4'h5
`define DEV_IN 4'h6
`define DEV_TS 4'h7
`define DEV_TC 4'h8
`define DEV_CS 4'h9
`define DEV_CC 4'ha
`define DEV_TN 4'hb
`define DEV_CN 4'hc
`define DEV_DATA 4'hd
`define DEV_SDATA 4'he
`define DEV_FILE 4'hf
`define DEV_LINK 4'h4

// Start-number band bases
`define CO_M_BASE 16'h0800
`define CO_S_BASE 16'h1000
`define CO_B_BASE 16'h1100
`define CO_F_BASE 16'h1500
`define CO_END 16'h1600
`define IR_TS_BASE 16'h0800
`define IR_TC_BASE 16'h0900
`define IR_CS_BASE 16'h0a00
`define IR_CC_BASE 16'h0b00
`define IR_END 16'h0c00
`define IN_CN_BASE 16'h0100
`define IN_END 16'h0200
`define HR_S_BASE 16'h0400
`define HR_W_BASE 16'h0500
`define HR_R_BASE 16'h0900
`define HR_END 16'h2900

// Status codes and fixed steps
`define STAT_OK 8'h00
`define STAT_BAD_REQ 8'h01
`define STAT_REMOTE 8'h02
`define STAT_BAD_CMD 8'h03
`define STEP_BIT 16'h0010
`define STEP_WORD 16'h0001
`define HDR_LAST 2'h3
`define FIFO_DEPTH 4

`endif

// *** design/smpt_pkg.sv ***
/*
 Types shared by both ends of the translator link.
 Assumes the constants header is compiled alongside.
*/
package smpt_pkg;
    typedef logic [15:0] smpt_word_t;
    typedef enum {SMPT_D_IDLE, SMPT_D_HDR, SMPT_D_DATA, SMPT_D_WAIT, SMPT_D_RDATA,
        SMPT_D_DONE, SMPT_D_FAIL} smpt_dev_state_e;
    typedef enum {SMPT_P_HDR, SMPT_P_WDATA, SMPT_P_STAT, SMPT_P_RDATA} smpt_plc_state_e;
endpackage : smpt_pkg

// *** design/smpt_link_if.sv ***
/*
 Word link between the translating master and the remote controller.
 Assumes both ends share one clock; valid/ready handshake in each direction.
*/
interface smpt_link_if;
    logic cmd_valid;
    logic cmd_ready;
    logic [15:0] cmd_data;
    logic rsp_valid;
    logic rsp_ready;
    logic [15:0] rsp_data;

    modport master (output cmd_valid, output cmd_data, input cmd_ready,
        input rsp_valid, input rsp_data, output rsp_ready);
    modport slave (input cmd_valid, input cmd_data, output cmd_ready,
        output rsp_valid, output rsp_data, input rsp_ready);
endinterface : smpt_link_if

// *** design/smpt_fifo.sv ***
/*
 Small synchronous FIFO with valid/ready on both sides.
 Assumes one clock and a synchronous active-low reset; depth is a power of two.
*/
module smpt_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW:0] wr_ptr, rd_ptr;
    logic push, pop;

    // Full when pointers differ only in the wrap bit
    assign in_ready_o = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign out_valid_o = (wr_ptr != rd_ptr);
    assign out_data_o = mem[rd_ptr[AW-1:0]];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Storage needs no reset; only pointers carry state
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end

    // Pointer update
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule : smpt_fifo

// *** design/smpt_dev_end.sv ***
/*
 Translating master: checks a native request, sends it on through a 4-word FIFO.
 Assumes one clock, synchronous active-low reset and a slave end on the link.
*/
// What this block does
// RQ1 - One slave per request, slave answers
// RQ2 - Request carries the unique slave address
// RQ3 - 01H/02H: address any, 1-2000 bits
// RQ4 - 03H: address to 65534, 1-125 words
// RQ5 - 04H: address to 32767, 1-125 words
// RQ6 - 05H: single coil, no length; the code refuses 05H
// RQ7 - 06H: single register to 65534, no length
// RQ8 - 0FH: many coils, 1-800 bits
// RQ9 - 10H: many registers, 1-100 words
// RQ10 - Convert native requests internally, user unchanged
// RQ11 - Only type 1 set, always master
// RQ12 - Bit reads in 16-point units, 512 max
// RQ13 - Word reads in points, 64 max
// RQ14 - Coil writes in 16-point units, 160 max
// RQ15 - Register writes in points, 64 max
// RQ16 - 08H becomes loopback, 254 characters max
// RQ17 - No model-specific commands or extended registers
// RQ18 - Coil start numbers map to bit bands
// RQ19 - Input relay numbers map to input bands
// RQ20 - Register numbers map to word bands
// RQ21 - Address selects remote and local location
// RQ22 - Non-negative offset shifts local store address
// RQ23 - Refuse bad requests without using link
`include "smpt_consts.svh"
module smpt_dev_end import smpt_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_b_i,
    smpt_link_if.master lnk,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic [7:0] req_fc_i,
    input wire logic [7:0] req_slave_i,
    input wire logic [15:0] req_addr_i,
    input wire logic [15:0] req_size_i,
    input wire logic [15:0] req_offset_i,
    input wire logic wr_valid_i,
    output logic wr_ready_o,
    input wire logic [15:0] wr_data_i,
    output logic rd_valid_o,
    output logic [15:0] rd_data_o,
    output logic [15:0] rd_addr_o,
    output logic done_o,
    output logic err_o,
    output logic [7:0] stat_o
);
    // Native range check joined with the far end's tighter per-command limits
    function automatic logic req_ok(input logic [7:0] fc, input logic [15:0] a,
        input logic [15:0] n);
        case (fc)
            `FC_RD_COIL, `FC_RD_INREL: req_ok = (n != 16'h0000) && (n <= `LIM_BIT_RD)
                && (n <= `PLC_BIT_RD); // RQ3 RQ12
            `FC_RD_HOLD: req_ok = (a <= `ADR_MAX_WORD) && (n != 16'h0000)
                && (n <= `LIM_WORD_RD) && (n <= `PLC_WORD_RD); // RQ4 RQ13
            `FC_RD_INREG: req_ok = (a <= `ADR_MAX_INREG) && (n != 16'h0000)
                && (n <= `LIM_WORD_RD) && (n <= `PLC_WORD_RD); // RQ5 RQ13
            `FC_WR_HOLD: req_ok = (a <= `ADR_MAX_WORD); // RQ7
            `FC_WR_COILS: req_ok = (n != 16'h0000) && (n <= `LIM_BIT_WR)
                && (n <= `PLC_BIT_WR); // RQ8 RQ14
            `FC_WR_HOLDS: req_ok = (a <= `ADR_MAX_WORD) && (n != 16'h0000)
                && (n <= `LIM_WORD_WR) && (n <= `PLC_WORD_WR); // RQ9 RQ15
            `FC_LOOP: req_ok = (n != 16'h0000) && (n <= `PLC_LOOP); // RQ16
            // Single-coil write has no command in the common set
            default: req_ok = 1'b0; // RQ6 RQ17 RQ23
        endcase
    endfunction : req_ok
    // Start number to {hit, device code, index within device}
    function automatic logic [20:0] map_dev(input logic [7:0] fc, input logic [15:0] a);
        map_dev = 21'h000000;
        case (fc)
            `FC_RD_COIL, `FC_WR_COILS: begin // RQ18
                if (a < `CO_M_BASE) map_dev = {1'b1, `DEV_OUT, a};
                else if (a < `CO_S_BASE) map_dev = {1'b1, `DEV_MREL, a - `CO_M_BASE};
                else if (a < `CO_B_BASE) map_dev = {1'b1, `DEV_SREL, a - `CO_S_BASE};
                else if (a < `CO_F_BASE) map_dev = {1'b1, `DEV_LREL, a - `CO_B_BASE};
                else if (a < `CO_END) map_dev = {1'b1, `DEV_ANN, a - `CO_F_BASE};
            end
            `FC_RD_INREL: begin // RQ19
                if (a < `IR_TS_BASE) map_dev = {1'b1, `DEV_IN, a};
                else if (a < `IR_TC_BASE) map_dev = {1'b1, `DEV_TS, a - `IR_TS_BASE};
                else if (a < `IR_CS_BASE) map_dev = {1'b1, `DEV_TC, a - `IR_TC_BASE};
                else if (a < `IR_CC_BASE) map_dev = {1'b1, `DEV_CS, a - `IR_CS_BASE};
                else if (a < `IR_END) map_dev = {1'b1, `DEV_CC, a - `IR_CC_BASE};
            end
            `FC_RD_INREG: begin // RQ20
                if (a < `IN_CN_BASE) map_dev = {1'b1, `DEV_TN, a};
                else if (a < `IN_END) map_dev = {1'b1, `DEV_CN, a - `IN_CN_BASE};
            end
            `FC_RD_HOLD, `FC_WR_HOLD, `FC_WR_HOLDS: begin // RQ20
                if (a < `HR_S_BASE) map_dev = {1'b1, `DEV_DATA, a};
                else if (a < `HR_W_BASE) map_dev = {1'b1, `DEV_SDATA, a - `HR_S_BASE};
                else if (a < `HR_R_BASE) map_dev = {1'b1, `DEV_LINK, a - `HR_W_BASE};
                else if (a < `HR_END) map_dev = {1'b1, `DEV_FILE, a - `HR_R_BASE};
            end
            `FC_LOOP: map_dev = {1'b1, `DEV_NONE, 16'h0000};
            default: map_dev = 21'h000000;
        endcase
    endfunction : map_dev
    // Native code to far-end command; 06H travels as a one-point word write
    function automatic logic [7:0] plc_cmd(input logic [7:0] fc);
        case (fc)
            `FC_RD_COIL, `FC_RD_INREL: plc_cmd = `CMD_BIT_RD; // RQ12
            `FC_RD_HOLD, `FC_RD_INREG: plc_cmd = `CMD_WORD_RD; // RQ13
            `FC_WR_COILS: plc_cmd = `CMD_BIT_WR; // RQ14
            `FC_WR_HOLD, `FC_WR_HOLDS: plc_cmd = `CMD_WORD_WR; // RQ15
            default: plc_cmd = `CMD_LOOP; // RQ16
        endcase
    endfunction : plc_cmd
    // Words on the link: bit types pack 16 points, loopback packs 2 characters
    function automatic logic [15:0] link_words(input logic [7:0] fc, input logic [15:0] n);
        case (fc)
            `FC_RD_COIL, `FC_RD_INREL, `FC_WR_COILS: link_words = (n + 16'h000f) >> 4;
            `FC_LOOP: link_words = (n + 16'h0001) >> 1;
            `FC_WR_HOLD: link_words = 16'h0001;
            default: link_words = n;
        endcase
    endfunction : link_words
    smpt_dev_state_e state;
    logic [7:0] slave_q, cmd_q, fail_code;
    logic [3:0] dev_q;
    logic [15:0] idx_q, cnt_q, base_q, k, hold, f_in_data;
    logic [1:0] hdr_k;
    logic hold_full, f_in_valid, f_in_ready, push, rsp_fire, has_wdata, has_rdata;
    logic [20:0] map_now;
    assign map_now = map_dev(req_fc_i, req_addr_i);
    assign has_wdata = (cmd_q == `CMD_BIT_WR) || (cmd_q == `CMD_WORD_WR) || (cmd_q == `CMD_LOOP);
    assign has_rdata = (cmd_q == `CMD_BIT_RD) || (cmd_q == `CMD_WORD_RD) || (cmd_q == `CMD_LOOP);
    assign push = f_in_valid && f_in_ready;
    assign lnk.rsp_ready = (state == SMPT_D_WAIT) || (state == SMPT_D_RDATA);
    assign rsp_fire = lnk.rsp_valid && lnk.rsp_ready;
    // Header words then payload feed the FIFO; user never sees the far-end format
    always_comb begin
        f_in_valid = 1'b0;
        f_in_data = hold;
        if (state == SMPT_D_HDR) begin
            f_in_valid = 1'b1;
            case (hdr_k)
                2'h0: f_in_data = {slave_q, cmd_q}; // RQ2 RQ10
                2'h1: f_in_data = {12'h000, dev_q};
                2'h2: f_in_data = idx_q;
                default: f_in_data = cnt_q;
            endcase
        end else if (state == SMPT_D_DATA) begin
            f_in_valid = hold_full;
        end
    end
    // The FIFO decouples word production from link back-pressure
    smpt_fifo #(.WIDTH(16), .DEPTH(`FIFO_DEPTH)) u_tx_fifo (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .in_valid_i(f_in_valid),
        .in_ready_o(f_in_ready),
        .in_data_i(f_in_data),
        .out_valid_o(lnk.cmd_valid),
        .out_ready_i(lnk.cmd_ready),
        .out_data_o(lnk.cmd_data)
    );
    // Request sequencing: one transaction in flight, so one slave per request
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            state <= SMPT_D_IDLE;
            req_ready_o <= 1'b0;
            slave_q <= 8'h00;
            cmd_q <= 8'h00;
            dev_q <= 4'h0;
            idx_q <= 16'h0000;
            cnt_q <= 16'h0000;
            base_q <= 16'h0000;
            k <= 16'h0000;
            hdr_k <= 2'h0;
            fail_code <= `STAT_OK;
        end else begin
            case (state)
                SMPT_D_IDLE: begin
                    req_ready_o <= 1'b1;
                    if (req_valid_i && req_ready_o) begin
                        req_ready_o <= 1'b0;
                        fail_code <= `STAT_OK;
                        slave_q <= req_slave_i; // RQ2
                        cmd_q <= plc_cmd(req_fc_i); // RQ11
                        dev_q <= map_now[19:16];
                        idx_q <= map_now[15:0];
                        cnt_q <= link_words(req_fc_i, req_size_i);
                        base_q <= req_addr_i + req_offset_i; // RQ21 RQ22
                        hdr_k <= 2'h0;
                        k <= 16'h0000;
                        if (req_ok(req_fc_i, req_addr_i, req_size_i) && map_now[20]) begin
                            state <= SMPT_D_HDR;
                        end else begin
                            fail_code <= `STAT_BAD_REQ;
                            state <= SMPT_D_FAIL; // RQ23
                        end
                    end
                end
                SMPT_D_HDR: if (push) begin
                    hdr_k <= hdr_k + 2'h1;
                    if (hdr_k == `HDR_LAST) begin
                        state <= has_wdata ? SMPT_D_DATA : SMPT_D_WAIT;
                    end
                end
                SMPT_D_DATA: if (push) begin
                    k <= k + 16'h0001;
                    if (k == cnt_q - 16'h0001) begin
                        k <= 16'h0000;
                        state <= SMPT_D_WAIT;
                    end
                end
                SMPT_D_WAIT: if (rsp_fire) begin
                    // The answer must come from the addressed slave with good status
                    if (lnk.rsp_data[15:8] != slave_q || lnk.rsp_data[7:0] != `STAT_OK) begin
                        fail_code <= `STAT_REMOTE;
                        state <= SMPT_D_FAIL; // RQ1
                    end else begin
                        state <= has_rdata ? SMPT_D_RDATA : SMPT_D_DONE;
                    end
                end
                SMPT_D_RDATA: if (rsp_fire) begin
                    base_q <= base_q + ((cmd_q == `CMD_BIT_RD) ? `STEP_BIT : `STEP_WORD); // RQ21
                    k <= k + 16'h0001;
                    if (k == cnt_q - 16'h0001) begin
                        state <= SMPT_D_DONE;
                    end
                end
                SMPT_D_DONE, SMPT_D_FAIL: state <= SMPT_D_IDLE;
                default: state <= SMPT_D_IDLE;
            endcase
        end
    end
    // One-word holding stage keeps wr_ready_o a flop at the cost of one word per three cycles
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            hold <= 16'h0000;
            hold_full <= 1'b0;
            wr_ready_o <= 1'b0;
        end else if (wr_ready_o && wr_valid_i) begin
            hold <= wr_data_i;
            hold_full <= 1'b1;
            wr_ready_o <= 1'b0;
        end else if (push && state == SMPT_D_DATA) begin
            hold_full <= 1'b0;
        end else begin
            wr_ready_o <= (state == SMPT_D_DATA) && !hold_full;
        end
    end
    // User-side results, all registered
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rd_valid_o <= 1'b0;
            rd_data_o <= 16'h0000;
            rd_addr_o <= 16'h0000;
            done_o <= 1'b0;
            err_o <= 1'b0;
            stat_o <= `STAT_OK;
        end else begin
            rd_valid_o <= (state == SMPT_D_RDATA) && rsp_fire;
            if ((state == SMPT_D_RDATA) && rsp_fire) begin
                rd_data_o <= lnk.rsp_data;
                rd_addr_o <= base_q; // RQ22
            end
            done_o <= (state == SMPT_D_DONE);
            err_o <= (state == SMPT_D_FAIL);
            if (state == SMPT_D_DONE || state == SMPT_D_FAIL) begin
                stat_o <= fail_code;
            end
        end
    end
endmodule : smpt_dev_end

// *** design/smpt_plc_end.sv ***
/*
 Remote controller end: takes far-end commands off the link, executes them on a
 local word store and answers the master.
 Assumes one clock, synchronous active-low reset and a unique my_addr_i.
*/
`include "smpt_consts.svh"
module smpt_plc_end
    import smpt_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    smpt_link_if.slave lnk,
    input wire logic [7:0] my_addr_i,
    output logic served_o,
    output logic [7:0] served_cmd_o
);
    smpt_plc_state_e state;
    smpt_word_t mem [0:255];
    smpt_word_t lbuf [0:127];
    smpt_word_t hdr [0:2];
    logic [1:0] hk;
    logic [15:0] k, cnt;
    logic [7:0] status, ix;
    logic mine, cmd_fire, rsp_fire, is_loop, takes_data;

    assign is_loop = (hdr[0][7:0] == `CMD_LOOP);
    assign takes_data = (hdr[0][7:0] == `CMD_BIT_WR) || (hdr[0][7:0] == `CMD_WORD_WR) || is_loop;
    assign ix = hdr[2][7:0] + k[7:0];
    assign status = (hdr[0][7:0] >= `CMD_BIT_RD && hdr[0][7:0] <= `CMD_LOOP) ? `STAT_OK
        : `STAT_BAD_CMD;
    assign lnk.cmd_ready = (state == SMPT_P_HDR) || (state == SMPT_P_WDATA);
    assign lnk.rsp_valid = (state == SMPT_P_STAT) || (state == SMPT_P_RDATA);
    assign lnk.rsp_data = (state == SMPT_P_STAT) ? {my_addr_i, status}
        : (is_loop ? lbuf[k[6:0]] : mem[ix]);
    assign cmd_fire = lnk.cmd_valid && lnk.cmd_ready;
    assign rsp_fire = lnk.rsp_valid && lnk.rsp_ready;

    // Store writes; other slaves' traffic is consumed but not applied
    always_ff @(posedge clk_i) begin
        if (cmd_fire && state == SMPT_P_WDATA && mine) begin
            if (is_loop) begin
                lbuf[k[6:0]] <= lnk.cmd_data;
            end else begin
                mem[ix] <= lnk.cmd_data;
            end
        end
    end

    // Command parse and reply sequencing
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            state <= SMPT_P_HDR;
            hk <= 2'h0;
            k <= 16'h0000;
            cnt <= 16'h0000;
            mine <= 1'b0;
            hdr[0] <= 16'h0000;
            hdr[1] <= 16'h0000;
            hdr[2] <= 16'h0000;
        end else begin
            case (state)
                SMPT_P_HDR: if (cmd_fire) begin
                    hk <= hk + 2'h1;
                    k <= 16'h0000;
                    if (hk != `HDR_LAST) begin
                        hdr[hk] <= lnk.cmd_data;
                    end else begin
                        cnt <= lnk.cmd_data;
                        mine <= (hdr[0][15:8] == my_addr_i); // RQ1 RQ2
                        if (takes_data) begin
                            state <= SMPT_P_WDATA;
                        end else if (hdr[0][15:8] == my_addr_i) begin
                            state <= SMPT_P_STAT;
                        end
                    end
                end
                SMPT_P_WDATA: if (cmd_fire) begin
                    k <= k + 16'h0001;
                    if (k == cnt - 16'h0001) begin
                        k <= 16'h0000;
                        state <= mine ? SMPT_P_STAT : SMPT_P_HDR;
                    end
                end
                SMPT_P_STAT: if (rsp_fire) begin
                    // Writes and bad commands end with the status word alone
                    if (status == `STAT_OK && !takes_data || is_loop) begin
                        state <= SMPT_P_RDATA;
                    end else begin
                        state <= SMPT_P_HDR;
                    end
                end
                SMPT_P_RDATA: if (rsp_fire) begin
                    k <= k + 16'h0001;
                    if (k == cnt - 16'h0001) begin
                        state <= SMPT_P_HDR;
                    end
                end
                default: state <= SMPT_P_HDR;
            endcase
        end
    end

    // Pulse once per answered command
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            served_o <= 1'b0;
            served_cmd_o <= 8'h00;
        end else begin
            served_o <= (state == SMPT_P_STAT) && rsp_fire;
            if ((state == SMPT_P_STAT) && rsp_fire) begin
                served_cmd_o <= hdr[0][7:0];
            end
        end
    end
endmodule : smpt_plc_end

// *** verification/smpt_link_monitor.sv ***
/*
 Link checker: handshake, idle and turn-taking rules on the word link.
 Assumes one clock, synchronous active-low reset, link signals as plain inputs.
*/
module smpt_link_monitor (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic [15:0] cmd_data,
    input wire logic rsp_valid,
    input wire logic rsp_ready,
    input wire logic [15:0] rsp_data
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // A stalled word stands unchanged, else the far end sees a torn header
    property p_cmd_hold; cmd_valid && !cmd_ready |=> cmd_valid; endproperty
    property p_cmd_data; cmd_valid && !cmd_ready |=> $stable(cmd_data); endproperty
    property p_rsp_hold; rsp_valid && !rsp_ready |=> rsp_valid; endproperty
    property p_rsp_data; rsp_valid && !rsp_ready |=> $stable(rsp_data); endproperty
    // Idle out of reset, one direction at a time, each word taken within four cycles
    property p_rst_idle; $rose(rst_b_i) |-> !cmd_valid && !rsp_valid ##1 !cmd_valid; endproperty
    property p_excl; rsp_valid |-> !cmd_valid; endproperty
    property p_cmd_go; cmd_valid |-> ##[0:4] cmd_ready; endproperty
    property p_rsp_go; rsp_valid |-> ##[0:4] rsp_ready; endproperty
    a_cmd_hold: assert property (p_cmd_hold) else $error("cmd word dropped");
    a_cmd_data: assert property (p_cmd_data) else $error("cmd data moved");
    a_rsp_hold: assert property (p_rsp_hold) else $error("rsp word dropped");
    a_rsp_data: assert property (p_rsp_data) else $error("rsp data moved");
    a_rst_idle: assert property (p_rst_idle) else $error("link busy after reset");
    a_excl: assert property (p_excl) else $error("both directions busy");
    a_cmd_go: assert property (p_cmd_go) else $error("cmd not taken");
    a_rsp_go: assert property (p_rsp_go) else $error("rsp not taken");
    c_cmd: cover property (cmd_valid && cmd_ready);
    c_rsp: cover property (rsp_valid && rsp_ready);
    c_stall: cover property (rsp_valid && !rsp_ready);
endmodule : smpt_link_monitor

// *** verification/serial_message_protocol_translator_tb.sv ***
/*
 Bench for both link ends: requests at the master's user side, echoes judged there.
 Assumes the design files and the link checker are compiled first.
*/
module serial_message_protocol_translator_tb import smpt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_b_i = 1'b0, req_valid_i = 1'b0, wr_valid_i = 1'b0;
    logic [7:0] req_fc_i = '0, req_slave_i = 8'h11;
    logic [15:0] req_addr_i = '0, req_size_i = '0, req_offset_i = '0, wr_data_i = '0;
    logic req_ready_o, wr_ready_o, rd_valid_o, done_o, err_o, served_o;
    logic [15:0] rd_data_o, rd_addr_o, ra0;
    logic [7:0] stat_o, served_cmd_o;
    int mismatches = 0, n_tests = 0;
    smpt_word_t rq[$], cw[$];
    smpt_link_if lk();
    smpt_dev_end smpt_dev_end_i (.clk_i, .rst_b_i, .lnk(lk), .req_valid_i, .req_ready_o,
        .req_fc_i, .req_slave_i, .req_addr_i, .req_size_i, .req_offset_i, .wr_valid_i,
        .wr_ready_o, .wr_data_i, .rd_valid_o, .rd_data_o, .rd_addr_o, .done_o, .err_o, .stat_o);
    smpt_plc_end smpt_plc_end_i (.clk_i, .rst_b_i, .lnk(lk), .my_addr_i(8'h11), .served_o,
        .served_cmd_o);
    smpt_link_monitor smpt_link_monitor_i (.clk_i, .rst_b_i, .cmd_valid(lk.cmd_valid),
        .cmd_ready(lk.cmd_ready), .cmd_data(lk.cmd_data), .rsp_valid(lk.rsp_valid),
        .rsp_ready(lk.rsp_ready), .rsp_data(lk.rsp_data));
    // 200 MHz clock
    always #2.5 clk_i = ~clk_i;
    // Log every command word taken on the link, to prove refusals stay off it
    always @(posedge clk_i) if (lk.cmd_valid && lk.cmd_ready) cw.push_back(lk.cmd_data);
    task automatic chk(input bit ok, input string m);
        n_tests++;
        if (!ok) begin
            mismatches++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask : chk
    // Payload words are always a0 upward, so every read back must match that run
    function automatic bit seq(input int n);
        seq = (rq.size() == n);
        foreach (rq[i]) seq &= (rq[i] === 16'h00a0 + 16'(i));
    endfunction : seq
    // One request: feed payload, gather reads, bounded wait for done or err
    task automatic run(input logic [7:0] fc, input logic [15:0] a, s, o, input int nw, bad);
        int k = 0, t = 0, sv = 0;
        bit fin = 0;
        cw.delete();
        rq.delete();
        req_fc_i <= fc;
        req_addr_i <= a;
        req_size_i <= s;
        req_offset_i <= o;
        req_valid_i <= 1'b1;
        do @(posedge clk_i); while (req_ready_o !== 1'b1);
        req_valid_i <= 1'b0;
        while (!fin && t < 3000) begin
            @(posedge clk_i);
            if (wr_valid_i && wr_ready_o === 1'b1) k++;
            wr_valid_i <= (k < nw);
            wr_data_i <= 16'h00a0 + 16'(k);
            if (rd_valid_o === 1'b1 && rq.size() == 0) ra0 = rd_addr_o;
            if (rd_valid_o === 1'b1) rq.push_back(rd_data_o);
            if (served_o === 1'b1) sv++;
            fin = (done_o === 1'b1) || (err_o === 1'b1);
            t++;
        end
        if (bad) chk(err_o === 1'b1 && stat_o === 8'h01 && cw.size() == 0, "refusal");
        else chk(done_o === 1'b1 && stat_o === 8'h00 && cw[0][15:8] === 8'h11, "req");
        chk(sv == (bad ? 0 : 1) && cw.size() == (bad ? 0 : 4 + nw), "answer");
    endtask : run
    task automatic t_words;
        run(8'h10, 16'h0064, 16'h0003, '0, 3, 0);
        run(8'h03, 16'h0064, 16'h0003, 16'h03e8, 0, 0);
        chk(seq(3), "hold read data");
        chk(ra0 === 16'h044c, "store address");
        run(8'h06, 16'h0067, '0, '0, 1, 0);
        run(8'h04, 16'h0067, 16'h0001, '0, 0, 0);
        chk(seq(1), "single write");
        $display("test words end");
    endtask : t_words
    task automatic t_bits;
        run(8'h0f, '0, 16'h0020, '0, 2, 0);
        run(8'h01, '0, 16'h0020, '0, 0, 0);
        chk(seq(2), "coil read data");
        run(8'h02, '0, 16'h0020, '0, 0, 0);
        chk(seq(2), "relay read data");
        $display("test bits end");
    endtask : t_bits
    task automatic t_loop;
        run(8'h08, '0, 16'h0004, '0, 2, 0);
        chk(seq(2) && served_cmd_o === 8'h05, "loopback echo");
        $display("test loop end");
    endtask : t_loop
    // Single coil, limits past the far-end caps, start beyond the bands
    task automatic t_refuse;
        logic [39:0] tab [5] = '{40'h05_0000_0001, 40'h03_0000_0041, 40'h04_0200_0001,
            40'h01_0000_0201, 40'h10_0000_0041};
        for (int i = 0; i < 5; i++) run(tab[i][39:32], tab[i][31:16], tab[i][15:0], '0, 0, 1);
        $display("test refuse end");
    endtask : t_refuse
    task automatic end_sim;
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    // Main sequence after a 16-cycle reset
    initial begin
        repeat (16) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        t_refuse();
        t_words();
        t_bits();
        t_loop();
        end_sim();
    end
    // Watchdog: the tests need a few hundred cycles, so 20000 means a hang
    initial begin
        #100us;
        mismatches++;
        end_sim();
    end
endmodule : serial_message_protocol_translator_tb
